// File: design/dbs_ack_decode.v
`timescale 1ns/1ps
`include "dbs_map.vh"

// Synchronises the active-low acknowledge pins and decodes the port width
module dbs_ack_decode
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Acknowledge pins, active low
    input wire ack_byte_port_n,
    input wire ack_word_port_n,
    // Decoded results
    output wire ack_wait,
    output wire ack_port8,
    output wire ack_port16,
    output wire ack_reserved
);

    reg [1:0] sync_a;
    reg [1:0] sync_b;

    // Two flip-flop synchroniser, first stage read only by the second
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= 2'h3;
            sync_b <= 2'h3;
        end
        else
        begin
            sync_a <= {ack_word_port_n, ack_byte_port_n};
            sync_b <= sync_a;
        end
    end

    // Decode of the synchronised pair
    assign ack_wait = sync_b[`DBS_ACK_WORD_BIT] & sync_b[`DBS_ACK_BYTE_BIT];
    assign ack_port8 = sync_b[`DBS_ACK_WORD_BIT] & ~sync_b[`DBS_ACK_BYTE_BIT];
    assign ack_port16 = ~sync_b[`DBS_ACK_WORD_BIT] & sync_b[`DBS_ACK_BYTE_BIT];
    assign ack_reserved = ~sync_b[`DBS_ACK_WORD_BIT] & ~sync_b[`DBS_ACK_BYTE_BIT];

endmodule

// File: design/dbs_port.v
`timescale 1ns/1ps
`include "dbs_map.vh"

module dbs_port
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Operand request from the core, same clock domain
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_size,
    input wire [23:0] req_addr,
    input wire [31:0] req_wdata,
    // Operand completion towards the core
    output reg done,
    output reg done_error,
    output reg [31:0] rdata,
    output reg busy,
    // Bus outputs
    output reg [22:0] word_base_lines,
    output reg byte_offset_line,
    output reg remaining_size_hi,
    output reg remaining_size_lo,
    output reg read_write,
    output reg addr_strobe_n,
    // Data lines as three signals; enable low while driving
    input wire [15:0] data_lines_in,
    output reg [15:0] data_lines_out,
    output reg data_lines_oe_n,
    // Acknowledge pins, active low
    input wire ack_byte_port_n,
    input wire ack_word_port_n
);

    // One-hot states
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_NEXT = 3'b100;

    reg [2:0] state;
    reg [31:0] op_data;
    reg [15:0] data_sync1;
    reg [15:0] data_sync2;
    reg is_long;
    reg req_size_word;
    reg ack_armed;
    wire ack_wait;
    wire ack_port8;
    wire ack_port16;
    wire ack_reserved;
    wire [1:0] size_now;
    wire [23:0] addr_now;
    wire [1:0] byte_index;
    wire [1:0] next_size;
    wire [23:0] next_addr;
    wire [15:0] next_wdata;
    wire [1:0] step;
    wire finish;

    // Acknowledge synchroniser and decoder
    dbs_ack_decode dbs_ack_decode_i
    (
        .clk(clk),
        .rst(rst),
        .ack_byte_port_n(ack_byte_port_n),
        .ack_word_port_n(ack_word_port_n),
        .ack_wait(ack_wait),
        .ack_port8(ack_port8),
        .ack_port16(ack_port16),
        .ack_reserved(ack_reserved)
    );

    // Data pins pass two flip-flops before being read
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            data_sync1 <= `DBS_DATA_RESET;
            data_sync2 <= `DBS_DATA_RESET;
        end
        else
        begin
            data_sync1 <= data_lines_in;
            data_sync2 <= data_sync1;
        end
    end

    // Current cycle view rebuilt from the held bus outputs
    assign size_now = {remaining_size_hi, remaining_size_lo};
    assign addr_now = {word_base_lines, byte_offset_line};

    // Operand byte number still at the head of the transfer
    assign byte_index = (size_now == `DBS_SIZE_LONG) ? 2'h0 :
                        (size_now == `DBS_SIZE_THREE) ? 2'h1 :
                        (size_now == `DBS_SIZE_WORD) ? (is_long ? 2'h2 : 2'h0) :
                        (is_long ? 2'h3 : (req_size_word ? 2'h1 : 2'h0));

    // Bytes moved by this ack: a byte port moves one, a word port up to two
    assign step = (ack_port8 | (size_now == `DBS_SIZE_BYTE)) ? 2'h1 : 2'h2;
    assign finish = (step == 2'h1) ? (size_now == `DBS_SIZE_BYTE) :
                    (size_now == `DBS_SIZE_WORD);

    // Size still remaining after this ack; three appears only after a byte ack on a long
    assign next_size = size_now - step;

    // Address steps by the bytes moved
    assign next_addr = addr_now + {22'h00_0000, step};

    // Write data for the next cycle: pair at the head on all sixteen lines, a last single byte on both halves
    assign next_wdata = wdata_for(next_size, is_long, op_data);

    // Picks the operand bytes driven onto the sixteen lines
    function [15:0] wdata_for;
        input [1:0] sz;
        input lng;
        input [31:0] d;
        begin
            case (sz)
                `DBS_SIZE_LONG: wdata_for = d[31:16];
                `DBS_SIZE_THREE: wdata_for = d[23:8];
                `DBS_SIZE_WORD: wdata_for = lng ? d[15:0] : d[31:16];
                default: wdata_for = lng ? {d[7:0], d[7:0]} : {d[23:16], d[23:16]};
            endcase
        end
    endfunction

    // Word operands start at bit 31 of the operand register so one function serves all
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            op_data <= 32'h0000_0000;
            is_long <= 1'b0;
            req_size_word <= 1'b0;
            ack_armed <= 1'b0;
            done <= 1'b0;
            done_error <= 1'b0;
            rdata <= 32'h0000_0000;
            busy <= 1'b0;
            word_base_lines <= 23'h00_0000;
            byte_offset_line <= 1'b0;
            remaining_size_hi <= 1'b0;
            remaining_size_lo <= 1'b0;
            read_write <= 1'b1;
            addr_strobe_n <= `DBS_STROBE_RESET;
            data_lines_out <= `DBS_DATA_RESET;
            data_lines_oe_n <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            done_error <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (req_valid)
                    begin
                        busy <= 1'b1;
                        // Misaligned words and longs are refused
                        if (req_addr[0] && (req_size != `DBS_OP_BYTE))
                        begin
                            done <= 1'b1;
                            done_error <= 1'b1;
                            busy <= 1'b0;
                        end
                        else
                        begin
                            is_long <= (req_size == `DBS_OP_LONG);
                            req_size_word <= (req_size == `DBS_OP_WORD);
                            op_data <= (req_size == `DBS_OP_LONG) ? req_wdata :
                                       (req_size == `DBS_OP_WORD) ? {req_wdata[15:0], 16'h0000} :
                                       {req_wdata[7:0], 24'h00_0000};
                            // First cycle asks for the whole operand, assuming a word port
                            remaining_size_hi <= req_size[1];
                            remaining_size_lo <= req_size[0];
                            word_base_lines <= req_addr[23:1];
                            byte_offset_line <= req_addr[0];
                            read_write <= ~req_write;
                            data_lines_oe_n <= ~req_write;
                            data_lines_out <= (req_size == `DBS_OP_LONG) ? req_wdata[31:16] :
                                              (req_size == `DBS_OP_WORD) ? req_wdata[15:0] :
                                              {req_wdata[7:0], req_wdata[7:0]};
                            addr_strobe_n <= 1'b0;
                            ack_armed <= 1'b0;
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT:
                begin
                    // A released pair must be seen first, so an ack still in the synchroniser is not reused
                    if (ack_wait)
                        ack_armed <= 1'b1;
                    // Outputs stay put until a valid width ack; reserved code is a wait
                    if (ack_armed && (ack_port8 | ack_port16))
                    begin
                        addr_strobe_n <= 1'b1;
                        // Read data latched only on the ack, lane chosen by port and offset
                        if (read_write)
                        begin
                            if (step == 2'h2)
                                rdata <= is_long && (size_now == `DBS_SIZE_WORD) ?
                                         {rdata[31:16], data_sync2} : {data_sync2, 16'h0000};
                            else if (ack_port16 && byte_offset_line)
                                rdata <= place_byte(rdata, byte_index, data_sync2[7:0]);
                            else
                                rdata <= place_byte(rdata, byte_index, data_sync2[15:8]);
                        end
                        if (finish)
                        begin
                            state <= ST_IDLE;
                            done <= 1'b1;
                            busy <= 1'b0;
                            data_lines_oe_n <= 1'b1;
                        end
                        else
                        begin
                            remaining_size_hi <= next_size[1];
                            remaining_size_lo <= next_size[0];
                            word_base_lines <= next_addr[23:1];
                            byte_offset_line <= next_addr[0];
                            data_lines_out <= next_wdata;
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT:
                begin
                    // Strobe gap before the following cycle of the same operand
                    addr_strobe_n <= 1'b0;
                    ack_armed <= 1'b0;
                    state <= ST_WAIT;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Writes one received byte into its operand position
    function [31:0] place_byte;
        input [31:0] cur;
        input [1:0] idx;
        input [7:0] b;
        begin
            case (idx)
                2'h0: place_byte = {b, cur[23:0]};
                2'h1: place_byte = {cur[31:24], b, cur[15:0]};
                2'h2: place_byte = {cur[31:16], b, cur[7:0]};
                default: place_byte = {cur[31:8], b};
            endcase
        end
    endfunction

endmodule

// File: shared/dbs_map.vh
`ifndef DBS_MAP_VH
`define DBS_MAP_VH

// Remaining-size codes on the size outputs
`define DBS_SIZE_BYTE 2'h1
`define DBS_SIZE_WORD 2'h2
`define DBS_SIZE_THREE 2'h3
`define DBS_SIZE_LONG 2'h0

// Operand size request codes from the user side
`define DBS_OP_BYTE 2'h1
`define DBS_OP_WORD 2'h2
`define DBS_OP_LONG 2'h0

// Acknowledge pair field positions (bit 1 word port, bit 0 byte port)
`define DBS_ACK_WORD_BIT 1
`define DBS_ACK_BYTE_BIT 0

// Reset values
`define DBS_ADDR_RESET 24'h00_0000
`define DBS_DATA_RESET 16'h0000
`define DBS_STROBE_RESET 1'b1

// Wait cycles beyond which a stalled cycle is still held (no limit), shown for timing count
`define DBS_MIN_CYCLE_CLKS 2

`endif

// File: verif/dbs_port_properties.sv
`timescale 1ns/1ps
`include "dbs_map.vh"
module dbs_port_properties
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Watched ports
    input wire busy,
    input wire [22:0] word_base_lines,
    input wire byte_offset_line,
    input wire remaining_size_hi,
    input wire remaining_size_lo,
    input wire read_write,
    input wire addr_strobe_n,
    input wire [15:0] data_lines_out,
    input wire data_lines_oe_n,
    input wire ack_byte_port_n,
    input wire ack_word_port_n
);
    // One clock domain, quiet during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [1:0] sz = {remaining_size_hi, remaining_size_lo};
    wire cyc = !addr_strobe_n;
    // Steps of a cycle: gap inside an operand, stalled waits
    sequence s_mid_gap;
        $rose(addr_strobe_n) && busy;
    endsequence
    sequence s_no_ack;
        (cyc && ack_byte_port_n && ack_word_port_n) [*3];
    endsequence
    sequence s_both_ack;
        (cyc && !ack_byte_port_n && !ack_word_port_n) [*3];
    endsequence
    a_hold_stable: assert property (cyc && $past(cyc) |-> $stable({word_base_lines, byte_offset_line, sz})
        && $stable({read_write, data_lines_out, data_lines_oe_n})) else $error("bus outputs moved in a cycle");
    a_wait_no_ack: assert property (s_no_ack |=> cyc)
        else $error("cycle ended without ack");
    a_reserved_wait: assert property (s_both_ack |=> cyc)
        else $error("reserved ack ended a cycle");
    a_three_odd: assert property (cyc && sz == `DBS_SIZE_THREE |-> byte_offset_line)
        else $error("three byte code at even address");
    a_even_wide: assert property (cyc && (sz == `DBS_SIZE_LONG || sz == `DBS_SIZE_WORD) |-> !byte_offset_line)
        else $error("wide transfer at odd address");
    a_write_drives: assert property (cyc |-> data_lines_oe_n == read_write)
        else $error("data drive does not match direction");
    a_byte_lanes: assert property (cyc && !read_write && sz == `DBS_SIZE_BYTE
        |-> data_lines_out[15:8] == data_lines_out[7:0]) else $error("byte write not on both lanes");
    a_mid_gap: assert property (s_mid_gap |=> cyc)
        else $error("next cycle of operand did not start");
endmodule

bind dbs_port dbs_port_properties dbs_port_properties_i (.clk, .rst, .busy, .word_base_lines, .byte_offset_line,
    .remaining_size_hi, .remaining_size_lo, .read_write, .addr_strobe_n, .data_lines_out, .data_lines_oe_n,
    .ack_byte_port_n, .ack_word_port_n);

// File: verif/dbs_port_tb.sv
`timescale 1ns/1ps
`include "dbs_map.vh"
module dbs_port_tb;
    typedef struct packed {logic w; logic [1:0] sz; logic [7:0] a; logic wide; logic [3:0] wt;
        logic [2:0] n; logic [7:0] seq;} dbs_row_t;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg req_valid = 1'b0;
    reg req_write = 1'b0;
    reg [1:0] req_size = 2'h0;
    reg [23:0] req_addr = 24'h00_0000;
    reg [31:0] req_wdata = 32'h0000_0000;
    reg wide = 1'b0;
    reg both = 1'b0;
    reg [3:0] waits = 4'h0;
    wire done, done_error, busy, byte_offset_line, remaining_size_hi, remaining_size_lo, read_write;
    wire addr_strobe_n, data_lines_oe_n, ack_byte_port_n, ack_word_port_n;
    wire [31:0] rdata;
    wire [22:0] word_base_lines;
    wire [15:0] data_lines_in, data_lines_out;
    integer bad_count = 0;
    integer comparisons = 0;
    integer i;
    integer ncyc = 0;
    reg [7:0] seq = 8'hff;
    reg [23:0] last_a = 24'h00_0000;
    reg prev_n = 1'b1;
    // Direction, size, address, port, waits, then bus cycles and size codes expected
    dbs_row_t rows [0:13] = '{
        '{1'b0, `DBS_OP_BYTE, 8'h10, 1'b0, 4'h0, 3'h1, 8'hfd},
        '{1'b0, `DBS_OP_BYTE, 8'h11, 1'b1, 4'h2, 3'h1, 8'hfd},
        '{1'b0, `DBS_OP_WORD, 8'h14, 1'b0, 4'h0, 3'h2, 8'hf9},
        '{1'b0, `DBS_OP_WORD, 8'h16, 1'b1, 4'h3, 3'h1, 8'hfe},
        '{1'b0, `DBS_OP_LONG, 8'h18, 1'b0, 4'h1, 3'h4, 8'h39},
        '{1'b0, `DBS_OP_LONG, 8'h1c, 1'b1, 4'hf, 3'h2, 8'hf2},
        '{1'b1, `DBS_OP_BYTE, 8'h80, 1'b1, 4'h0, 3'h1, 8'hfd},
        '{1'b1, `DBS_OP_BYTE, 8'h81, 1'b1, 4'h1, 3'h1, 8'hfd},
        '{1'b1, `DBS_OP_BYTE, 8'h82, 1'b0, 4'h0, 3'h1, 8'hfd},
        '{1'b1, `DBS_OP_WORD, 8'h84, 1'b0, 4'h2, 3'h2, 8'hf9},
        '{1'b1, `DBS_OP_WORD, 8'h86, 1'b1, 4'h0, 3'h1, 8'hfe},
        '{1'b1, `DBS_OP_LONG, 8'h88, 1'b0, 4'h0, 3'h4, 8'h39},
        '{1'b1, `DBS_OP_LONG, 8'h8c, 1'b1, 4'h1, 3'h2, 8'hf2},
        '{1'b0, `DBS_OP_WORD, 8'h21, 1'b1, 4'h0, 3'h0, 8'hff}};
    dbs_port dbs_port_i (.clk, .rst, .req_valid, .req_write, .req_size, .req_addr, .req_wdata, .done,
        .done_error, .rdata, .busy, .word_base_lines, .byte_offset_line, .remaining_size_hi, .remaining_size_lo,
        .read_write, .addr_strobe_n, .data_lines_in, .data_lines_out, .data_lines_oe_n, .ack_byte_port_n,
        .ack_word_port_n);
    dbs_slave_model dbs_slave_model_i (.clk, .wide, .both, .waits, .word_base_lines, .byte_offset_line,
        .remaining_size_hi, .remaining_size_lo, .read_write, .addr_strobe_n, .data_lines_out, .data_lines_in,
        .ack_byte_port_n, .ack_word_port_n);
    // Compare one value, count it
    task check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Report counts and verdict
    task complete_run;
        begin
            $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // One operand through the port, then every result compared
    task run_op(input dbs_row_t r);
        integer t, j, k;
        logic [31:0] d;
        begin
            d = {4{r.a}} ^ 32'h1234_5678;
            k = (r.sz == `DBS_OP_BYTE) ? 1 : (r.sz == `DBS_OP_WORD) ? 2 : 4;
            @(negedge clk);
            {req_write, req_size, wide, waits} = {r.w, r.sz, r.wide, r.wt};
            req_addr = {16'h0000, r.a};
            req_wdata = d;
            req_valid = 1'b1;
            ncyc = 0;
            seq = 8'hff;
            @(negedge clk);
            req_valid = 1'b0;
            t = 0;
            while (done !== 1'b1 && t < 200)
            begin
                @(negedge clk);
                t = t + 1;
            end
            check_val("done", 32'h1, done);
            check_val("error", r.n == 0, done_error);
            check_val("cycles", r.n, ncyc);
            check_val("sizes", r.seq, seq);
            if (r.n != 0)
            begin
                check_val("last addr", r.a + (r.n - 1) * (r.wide ? 2 : 1), last_a);
                for (j = 0; j < k; j = j + 1)
                    if (r.w)
                        check_val("stored", d[8 * (k - 1 - j) +: 8], dbs_slave_model_i.mem[r.a + j]);
                    else
                        check_val("rdata", (r.a + j) ^ 8'h5a, rdata[31 - 8 * j -: 8]);
            end
        end
    endtask
    // Log each bus cycle start: count, size code, address
    always @(posedge clk)
    begin
        if (!addr_strobe_n && prev_n)
        begin
            ncyc = ncyc + 1;
            seq = {seq[5:0], remaining_size_hi, remaining_size_lo};
            last_a = {word_base_lines, byte_offset_line};
        end
        prev_n = addr_strobe_n;
    end
    // System clock
    initial
    begin
        forever #2 clk = ~clk;
    end
    // Watchdog
    initial
    begin
        #80000;
        bad_count = bad_count + 1;
        complete_run;
    end
    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 14; i = i + 1)
            run_op(rows[i]);
        // Both acks low stretch the cycle until one clears
        both = 1'b1;
        fork
            run_op('{1'b0, `DBS_OP_BYTE, 8'h30, 1'b1, 4'h0, 3'h1, 8'hfd});
            begin
                repeat (12) @(negedge clk);
                check_val("reserved wait", 32'h0, addr_strobe_n);
                both = 1'b0;
            end
        join
        // Reset in a stalled cycle ends it, then a normal operand
        {req_size, waits, req_valid} = {`DBS_OP_LONG, 4'hf, 1'b1};
        @(negedge clk);
        req_valid = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        check_val("strobe in reset", 32'h1, addr_strobe_n);
        check_val("busy in reset", 32'h0, busy);
        rst = 1'b0;
        run_op(rows[4]);
        complete_run;
    end
endmodule

// File: verif/dbs_slave_model.sv
`timescale 1ns/1ps
`include "dbs_map.vh"
module dbs_slave_model
(
    // Clock and behaviour controls
    input wire clk,
    input wire wide,
    input wire both,
    input wire [3:0] waits,
    // Bus from the master
    input wire [22:0] word_base_lines,
    input wire byte_offset_line,
    input wire remaining_size_hi,
    input wire remaining_size_lo,
    input wire read_write,
    input wire addr_strobe_n,
    input wire [15:0] data_lines_out,
    // Answers to the master
    output wire [15:0] data_lines_in,
    output wire ack_byte_port_n,
    output wire ack_word_port_n
);
    reg [7:0] mem [0:255];
    reg [3:0] cnt = 4'h0;
    reg acking = 1'b0;
    integer i;
    wire [7:0] a = {word_base_lines[6:0], byte_offset_line};
    wire [7:0] ae = {word_base_lines[6:0], 1'b0};
    wire on = acking && !addr_strobe_n;
    // Word port fills both lanes, byte port the upper one with its inverse on the lower
    wire [15:0] rd = wide ? {mem[ae], mem[ae | 8'h01]} : {mem[a], ~mem[a]};
    // Released lines show the inverse so stale data cannot match
    assign data_lines_in = (on && read_write) ? rd : ~rd;
    // Acks drop away as soon as the strobe rises
    assign ack_byte_port_n = !(on && (!wide || both));
    assign ack_word_port_n = !(on && (wide || both));
    // Distinct start contents
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] ^ 8'h5a;
    end
    // Count wait states, then answer and store write data once
    always @(posedge clk)
    begin
        if (addr_strobe_n)
        begin
            cnt <= 4'h0;
            acking <= 1'b0;
        end
        else if (!acking)
        begin
            cnt <= cnt + 4'h1;
            if (cnt == waits)
            begin
                acking <= 1'b1;
                if (!read_write && !wide)
                    mem[a] <= data_lines_out[15:8];
                else if (!read_write && {remaining_size_hi, remaining_size_lo} == `DBS_SIZE_BYTE)
                    mem[a] <= byte_offset_line ? data_lines_out[7:0] : data_lines_out[15:8];
                else if (!read_write)
                    {mem[ae], mem[ae | 8'h01]} <= data_lines_out;
            end
        end
    end
endmodule
